// ==== verilog/unsigned_simd_add_unit.sv ====
// unsigned packed add unit with its own operand register bank
// assumes a classic Wishbone master on CLK; RST is synchronous, active high
//
// Contract
// - halfword add keeps low sixteen bits
// - byte add keeps low eight bits
// - halfword carry sets flag pair per lane
// - byte carry sets one flag per lane
// - no destination means write first source
// - failed predicate changes neither register nor flags
// - add-sub exchange: low diff, high sum
// - add-sub exchange flags: no borrow, carry
// - sub-add exchange: low sum, high diff
// - sub-add exchange flags: carry, no borrow
// - halving halfword add shifts sum right
// - halving byte add shifts sum right
// - halving adds leave flags untouched
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module unsigned_simd_add_unit
	import simd_add_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	input  wire logic        WE_I,
	input  wire logic [7:0]  ADR_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic [31:0] DAT_I,
	output logic      [31:0] DAT_O,
	output logic             ACK_O
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	simd_alu_if alu_bus ();

	logic [31:0] ctrl;
	logic [31:0] result;
	logic [3:0]  lane_compare_flags;
	logic [31:0] gpr [GPR_COUNT];
	logic        last_done;
	logic        last_skip;
	logic        last_badreg;
	logic        last_badop;
	logic [7:0]  exec_count;

	logic        bus_req;
	logic        bus_commit;
	logic        bus_write;
	logic [7:0]  word_addr;
	logic        hit_ctrl;
	logic        hit_issue;
	logic        hit_flags;
	logic        hit_gpr;
	logic [3:0]  gpr_sel;
	logic [31:0] next_read_data;

	op_t         op_sel;
	logic        cond_pass;
	logic        dest_given;
	logic [3:0]  dest_field;
	logic [3:0]  first_src_reg;
	logic [3:0]  second_src_reg;
	logic [3:0]  dest_reg;
	logic        issue_go;
	logic        reg_forbidden;
	logic        exec_now;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] merge_lanes(
		input logic [31:0] old_word,
		input logic [31:0] new_word,
		input logic [3:0]  sel
	);
		logic [31:0] merged;
		merged = old_word;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				merged[8*i +: 8] = new_word[8*i +: 8];
			end
		end
		return merged;
	endfunction

	function automatic logic is_reserved_reg(input logic [3:0] idx);
		return (idx == STACK_PTR_IDX) || (idx == PROG_CNT_IDX);
	endfunction

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	assign bus_req    = CYC_I && STB_I;
	// a write takes effect only on the edge at which ack is seen high
	assign bus_commit = bus_req && ACK_O;
	assign bus_write  = bus_commit && WE_I;
	assign word_addr  = {ADR_I[7:2], 2'b00};
	assign hit_ctrl   = (word_addr == CTRL_OFF);
	assign hit_issue  = (word_addr == ISSUE_OFF);
	assign hit_flags  = (word_addr == FLAGS_OFF);
	assign hit_gpr    = (ADR_I[7:6] == GPR_REGION);
	assign gpr_sel    = ADR_I[5:2];

	// ----------------------------------------------------------------
	// issue decode
	// ----------------------------------------------------------------
	assign op_sel         = op_t'(ctrl[CTRL_OP_LSB +: 3]);
	assign cond_pass      = ctrl[CTRL_COND_BIT];
	assign dest_given     = ctrl[CTRL_DGIVEN_BIT];
	assign dest_field     = ctrl[CTRL_DEST_LSB +: 4];
	assign first_src_reg  = ctrl[CTRL_FIRST_LSB +: 4];
	assign second_src_reg = ctrl[CTRL_SECOND_LSB +: 4];
	assign dest_reg       = dest_given ? dest_field : first_src_reg;

	// refuse any issue that names the stack pointer or program counter
	assign reg_forbidden  = is_reserved_reg(dest_reg)
	                     || is_reserved_reg(first_src_reg)
	                     || is_reserved_reg(second_src_reg);

	assign issue_go = bus_write && hit_issue && SEL_I[0] && DAT_I[ISSUE_GO_BIT];
	assign exec_now = issue_go && cond_pass && !reg_forbidden && alu_bus.op_valid;

	// ----------------------------------------------------------------
	// lane datapath
	// ----------------------------------------------------------------
	assign alu_bus.opa = gpr[first_src_reg];
	assign alu_bus.opb = gpr[second_src_reg];
	assign alu_bus.op  = op_sel;

	simd_lane_alu u_lane_alu (
		.port (alu_bus.alu)
	);

	// ----------------------------------------------------------------
	// bus acknowledge
	// ----------------------------------------------------------------
	// one wait state; ack drops the cycle after it was given
	always_ff @(posedge CLK) begin
		if (RST) begin
			ACK_O <= 1'b0;
		end else begin
			ACK_O <= bus_req && !ACK_O;
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_comb begin
		next_read_data = 32'h0000_0000;
		if (hit_gpr) begin
			next_read_data = gpr[gpr_sel];
		end else begin
			case (word_addr)
				CTRL_OFF: begin
					next_read_data = ctrl;
				end
				FLAGS_OFF: begin
					next_read_data = {28'h0000000, lane_compare_flags};
				end
				STATUS_OFF: begin
					next_read_data[STAT_DONE_BIT]          = last_done;
					next_read_data[STAT_SKIP_BIT]          = last_skip;
					next_read_data[STAT_BADREG_BIT]        = last_badreg;
					next_read_data[STAT_BADOP_BIT]         = last_badop;
					next_read_data[STAT_COUNT_LSB +: 8]    = exec_count;
				end
				RESULT_OFF: begin
					next_read_data = result;
				end
				default: begin
					next_read_data = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			DAT_O <= WORD_RESET;
		end else if (bus_req && !ACK_O && !WE_I) begin
			DAT_O <= next_read_data;
		end
	end

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RST) begin
			ctrl <= CTRL_RESET;
		end else if (bus_write && hit_ctrl) begin
			ctrl <= merge_lanes(ctrl, DAT_I, SEL_I);
		end
	end

	// ----------------------------------------------------------------
	// operand register bank
	// ----------------------------------------------------------------
	// an executed result wins over a software write in the same edge
	always_ff @(posedge CLK) begin
		if (RST) begin
			for (int i = 0; i < GPR_COUNT; i++) begin
				gpr[i] <= WORD_RESET;
			end
		end else if (exec_now) begin
			gpr[dest_reg] <= alu_bus.result;
		end else if (bus_write && hit_gpr) begin
			gpr[gpr_sel] <= merge_lanes(gpr[gpr_sel], DAT_I, SEL_I);
		end
	end

	// ----------------------------------------------------------------
	// last result
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RST) begin
			result <= WORD_RESET;
		end else if (exec_now) begin
			result <= alu_bus.result;
		end
	end

	// ----------------------------------------------------------------
	// lane compare flags
	// ----------------------------------------------------------------
	// halving forms report no flag write, so the flags hold
	always_ff @(posedge CLK) begin
		if (RST) begin
			lane_compare_flags <= FLAGS_RESET;
		end else if (exec_now && alu_bus.ge_write) begin
			lane_compare_flags <= alu_bus.ge;
		end else if (bus_write && hit_flags && SEL_I[0]) begin
			lane_compare_flags <= DAT_I[3:0];
		end
	end

	// ----------------------------------------------------------------
	// issue outcome
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RST) begin
			last_done   <= 1'b0;
			last_skip   <= 1'b0;
			last_badreg <= 1'b0;
			last_badop  <= 1'b0;
		end else if (issue_go) begin
			last_done   <= exec_now;
			last_skip   <= !cond_pass;
			last_badreg <= reg_forbidden;
			last_badop  <= !alu_bus.op_valid;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			exec_count <= COUNT_RESET;
		end else if (exec_now) begin
			exec_count <= exec_count + 8'h01;
		end
	end

endmodule
`default_nettype wire

// ==== shared/simd_add_pkg.sv ====
// constants, types and register map of the unsigned packed add unit
// assumes a 32-bit classic Wishbone slave port with byte addresses
package simd_add_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFF     = 8'h00;
	localparam logic [7:0] ISSUE_OFF    = 8'h04;
	localparam logic [7:0] FLAGS_OFF    = 8'h08;
	localparam logic [7:0] STATUS_OFF   = 8'h0C;
	localparam logic [7:0] RESULT_OFF   = 8'h10;
	localparam logic [1:0] GPR_REGION   = 2'h1;

	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_OP_LSB      = 0;
	localparam int CTRL_COND_BIT    = 3;
	localparam int CTRL_DGIVEN_BIT  = 4;
	localparam int CTRL_DEST_LSB    = 8;
	localparam int CTRL_FIRST_LSB   = 12;
	localparam int CTRL_SECOND_LSB  = 16;
	localparam int ISSUE_GO_BIT     = 0;

	// ----------------------------------------------------------------
	// status register fields
	// ----------------------------------------------------------------
	localparam int STAT_DONE_BIT    = 0;
	localparam int STAT_SKIP_BIT    = 1;
	localparam int STAT_BADREG_BIT  = 2;
	localparam int STAT_BADOP_BIT   = 3;
	localparam int STAT_COUNT_LSB   = 8;

	// ----------------------------------------------------------------
	// reset values and fixed register indexes
	// ----------------------------------------------------------------
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0008;
	localparam logic [31:0] WORD_RESET   = 32'h0000_0000;
	localparam logic [3:0]  FLAGS_RESET  = 4'h0;
	localparam logic [7:0]  COUNT_RESET  = 8'h00;
	localparam logic [3:0]  STACK_PTR_IDX = 4'hD;
	localparam logic [3:0]  PROG_CNT_IDX  = 4'hF;
	localparam int          GPR_COUNT     = 16;

	// ----------------------------------------------------------------
	// operation select
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_LANE_ADD_HALFWORDS    = 3'h0,
		OP_LANE_ADD_BYTES        = 3'h1,
		OP_ADD_SUB_EXCHANGE      = 3'h2,
		OP_SUB_ADD_EXCHANGE      = 3'h3,
		OP_HALVING_ADD_HALFWORDS = 3'h4,
		OP_HALVING_ADD_BYTES     = 3'h5,
		OP_SPARE_6               = 3'h6,
		OP_SPARE_7               = 3'h7
	} op_t;

endpackage

// ==== shared/simd_alu_if.sv ====
// operand, select and result bundle between issue logic and lane datapath
// assumes both ends sit on the same clock; the bundle is purely combinational
`timescale 1ns/1ps
`default_nettype none
interface simd_alu_if import simd_add_pkg::*; ;
	logic [31:0] opa;
	logic [31:0] opb;
	op_t         op;
	logic [31:0] result;
	logic [3:0]  ge;
	logic        ge_write;
	logic        op_valid;

	modport alu (
		input  opa,
		input  opb,
		input  op,
		output result,
		output ge,
		output ge_write,
		output op_valid
	);

	modport issue (
		output opa,
		output opb,
		output op,
		input  result,
		input  ge,
		input  ge_write,
		input  op_valid
	);
endinterface
`default_nettype wire

// ==== verilog/simd_lane_alu.sv ====
// combinational lane datapath of the unsigned packed add unit
// assumes operands and select are stable for the cycle in which they are used
`timescale 1ns/1ps
`default_nettype none
module simd_lane_alu
	import simd_add_pkg::*;
(
	simd_alu_if.alu port
);

	// ----------------------------------------------------------------
	// lane sums, one bit wider than the lane
	// ----------------------------------------------------------------
	logic [16:0] hw_sum [2];
	logic [8:0]  byte_sum [4];
	logic [16:0] asx_lo_diff;
	logic [16:0] asx_hi_sum;
	logic [16:0] sax_lo_sum;
	logic [16:0] sax_hi_diff;

	genvar h;
	generate
		for (h = 0; h < 2; h++) begin : g_hw
			assign hw_sum[h] = {1'b0, port.opa[16*h +: 16]} + {1'b0, port.opb[16*h +: 16]};
		end
	endgenerate

	genvar k;
	generate
		for (k = 0; k < 4; k++) begin : g_byte
			assign byte_sum[k] = {1'b0, port.opa[8*k +: 8]} + {1'b0, port.opb[8*k +: 8]};
		end
	endgenerate

	// bit 16 of a difference is the borrow, so it is clear when non-negative
	assign asx_lo_diff = {1'b0, port.opa[15:0]} - {1'b0, port.opb[31:16]};
	assign asx_hi_sum  = {1'b0, port.opa[31:16]} + {1'b0, port.opb[15:0]};
	assign sax_lo_sum  = {1'b0, port.opa[15:0]} + {1'b0, port.opb[31:16]};
	assign sax_hi_diff = {1'b0, port.opa[31:16]} - {1'b0, port.opb[15:0]};

	// ----------------------------------------------------------------
	// select
	// ----------------------------------------------------------------
	always_comb begin
		port.result   = 32'h0000_0000;
		port.ge       = 4'h0;
		port.ge_write = 1'b0;
		port.op_valid = 1'b1;
		case (port.op)
			OP_LANE_ADD_HALFWORDS: begin
				port.result   = {hw_sum[1][15:0], hw_sum[0][15:0]};
				port.ge       = {{2{hw_sum[1][16]}}, {2{hw_sum[0][16]}}};
				port.ge_write = 1'b1;
			end
			OP_LANE_ADD_BYTES: begin
				port.result   = {byte_sum[3][7:0], byte_sum[2][7:0],
				                 byte_sum[1][7:0], byte_sum[0][7:0]};
				port.ge       = {byte_sum[3][8], byte_sum[2][8],
				                 byte_sum[1][8], byte_sum[0][8]};
				port.ge_write = 1'b1;
			end
			OP_ADD_SUB_EXCHANGE: begin
				port.result   = {asx_hi_sum[15:0], asx_lo_diff[15:0]};
				port.ge       = {{2{asx_hi_sum[16]}}, {2{~asx_lo_diff[16]}}};
				port.ge_write = 1'b1;
			end
			OP_SUB_ADD_EXCHANGE: begin
				port.result   = {sax_hi_diff[15:0], sax_lo_sum[15:0]};
				port.ge       = {{2{~sax_hi_diff[16]}}, {2{sax_lo_sum[16]}}};
				port.ge_write = 1'b1;
			end
			OP_HALVING_ADD_HALFWORDS: begin
				port.result = {hw_sum[1][16:1], hw_sum[0][16:1]};
			end
			OP_HALVING_ADD_BYTES: begin
				port.result = {byte_sum[3][8:1], byte_sum[2][8:1],
				               byte_sum[1][8:1], byte_sum[0][8:1]};
			end
			default: begin
				port.op_valid = 1'b0;
			end
		endcase
	end

endmodule
`default_nettype wire

// ==== testbench/simd_add_chk.sv ====
// checker for the packed add unit: bus timing and flag behaviour
// assumes software writes CTRL as a whole word
`timescale 1ns/1ps
`default_nettype none
module simd_add_chk
	import simd_add_pkg::*;
(
	input wire logic        CLK,
	input wire logic        RST,
	input wire logic        CYC_I,
	input wire logic        STB_I,
	input wire logic        WE_I,
	input wire logic [7:0]  ADR_I,
	input wire logic [3:0]  SEL_I,
	input wire logic [31:0] DAT_I,
	input wire logic [31:0] DAT_O,
	input wire logic        ACK_O
);
	logic [19:0] ctrl;
	logic [3:0]  flg;
	logic        held;
	logic        pair;
	logic        req;
	logic        wr;
	logic        rd;
	logic        go;
	logic        quiet;
	logic        flg_rd;
	logic        flg_wr;

	assign req = CYC_I && STB_I && !ACK_O;
	assign wr = ACK_O && WE_I;
	assign rd = ACK_O && !WE_I;
	assign go = wr && ADR_I == ISSUE_OFF && SEL_I[0] && DAT_I[0];
	assign flg_rd = rd && ADR_I == FLAGS_OFF;
	assign flg_wr = wr && ADR_I == FLAGS_OFF;
	// issues that may not touch the flags: failed predicate, halving or spare op, forbidden source or destination
	assign quiet = !ctrl[3] || ctrl[2] || ctrl[15:12] == 4'hD || ctrl[15:12] == 4'hF
		|| ctrl[19:16] == 4'hD || ctrl[19:16] == 4'hF
		|| (ctrl[4] && (ctrl[11:8] == 4'hD || ctrl[11:8] == 4'hF));

	always_ff @(posedge CLK) begin
		if (RST) begin
			ctrl <= CTRL_RESET[19:0];
			held <= 1'b0;
			pair <= 1'b0;
		end else begin
			if (wr && ADR_I == CTRL_OFF)
				ctrl <= DAT_I[19:0];
			if (flg_rd) begin
				flg <= DAT_O[3:0];
				held <= 1'b1;
			end
			if ((go && !quiet) || flg_wr)
				held <= 1'b0;
			if (go && !quiet)
				pair <= ctrl[2:0] != 3'h1;
			if (flg_wr)
				pair <= 1'b0;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	AST_ACK_NEXT: assert property (req |=> ACK_O)
		else $error("no ack in the cycle after a request");
	AST_ACK_PULSE: assert property (ACK_O |=> !ACK_O)
		else $error("ack longer than one cycle");
	AST_NO_STRAY_ACK: assert property ($rose(ACK_O) |-> $past(CYC_I && STB_I))
		else $error("ack without a request");
	AST_DAT_HOLD: assert property (!(req && !WE_I) |=> $stable(DAT_O))
		else $error("read data moved without a read");
	AST_UNMAPPED_ZERO: assert property (rd && ((ADR_I >= 8'h14 && ADR_I < 8'h40)
		|| ADR_I >= 8'h80) |-> DAT_O == 32'h0)
		else $error("unmapped read not zero");
	AST_FLAGS_WIDTH: assert property (flg_rd |-> DAT_O[31:4] == 28'h0)
		else $error("flags read wider than four bits");
	AST_FLAG_PAIRS: assert property (flg_rd && pair
		|-> DAT_O[1] == DAT_O[0] && DAT_O[3] == DAT_O[2])
		else $error("halfword flags not set in pairs");
	AST_FLAGS_HELD: assert property (flg_rd && held |-> DAT_O[3:0] == flg)
		else $error("flags changed by an issue that must keep them");
	AST_RESET_QUIET: assert property (disable iff (1'b0) RST |=> !ACK_O && DAT_O == 32'h0)
		else $error("bus outputs not quiet after reset");

	COV_ISSUE: cover property (go && !quiet);
	COV_HELD: cover property (flg_rd && held);
	COV_STATUS: cover property (rd && ADR_I == STATUS_OFF);
endmodule
`default_nettype wire

// ==== testbench/issue_master.sv ====
// bus master standing in for decode, issue and software
// assumes the slave raises ack once for each request
`timescale 1ns/1ps
`default_nettype none
module issue_master (
	input  wire logic        clk,
	input  wire logic        ack,
	input  wire logic [31:0] rdata,
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic [7:0]       adr,
	output logic [3:0]       sel,
	output logic [31:0]      wdata
);
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		wdata = 32'h0;
	end

	// idle cycles before the request let the bench act slow or prompt
	task automatic xfer(input int idle, input logic w, input logic [7:0] a,
		input logic [3:0] s, input logic [31:0] d, output logic [31:0] q);
		repeat (idle + 1) @(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdata <= d;
		do
			@(posedge clk);
		while (ack !== 1'b1);
		q = rdata;
		cyc <= 1'b0;
		stb <= 1'b0;
		adr <= ~a;
		wdata <= ~d;
	endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench for the packed add unit
// assumes one-cycle ack; bank words 1, 2, 3 serve as sources and destination
`timescale 1ns/1ps
`default_nettype none
module tb import simd_add_pkg::*; ;
	typedef struct {
		op_t         op;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] res;
		logic [3:0]  flg;
	} row_t;

	logic        clk;
	logic        rst;
	logic        cyc;
	logic        stb;
	logic        we;
	logic        ack;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] q;
	int          n_mismatch;
	int          cmp_count;
	int          cycles = 0;
	row_t        rows [9] = '{
		'{OP_LANE_ADD_HALFWORDS, 32'hFFFF0001, 32'h0001FFFF, 32'h00000000, 4'hF},
		'{OP_LANE_ADD_HALFWORDS, 32'h7FFF8000, 32'h80007FFF, 32'hFFFFFFFF, 4'h0},
		'{OP_LANE_ADD_BYTES, 32'hFF80017F, 32'h0180FF80, 32'h000000FF, 4'hE},
		'{OP_ADD_SUB_EXCHANGE, 32'h12340005, 32'h0005EDCC, 32'h00000000, 4'hF},
		'{OP_ADD_SUB_EXCHANGE, 32'h00010004, 32'h00050002, 32'h0003FFFF, 4'h0},
		'{OP_SUB_ADD_EXCHANGE, 32'h00038000, 32'h80000004, 32'hFFFF0000, 4'h3},
		'{OP_SUB_ADD_EXCHANGE, 32'h00040001, 32'h00020004, 32'h00000003, 4'hC},
		'{OP_HALVING_ADD_HALFWORDS, 32'hFFFF0003, 32'hFFFF0004, 32'hFFFF0003, 4'hC},
		'{OP_HALVING_ADD_BYTES, 32'hFF018000, 32'hFF028001, 32'hFF018000, 4'hC}};
	// forbidden indexes 13 and 15 are sent on purpose here
	logic [31:0] bad_ctrl [6] = '{32'h00021311, 32'h0002D318, 32'h000F1318, 32'h0002131E,
		32'h00021F18, 32'h0002131F};
	int          bad_bit [6] = '{STAT_SKIP_BIT, STAT_BADREG_BIT, STAT_BADREG_BIT, STAT_BADOP_BIT,
		STAT_BADREG_BIT, STAT_BADOP_BIT};

	unsigned_simd_add_unit u_unsigned_simd_add_unit (.CLK(clk), .RST(rst), .CYC_I(cyc),
		.STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdata), .DAT_O(rdata),
		.ACK_O(ack));
	issue_master u_issue_master (.clk(clk), .ack(ack), .rdata(rdata), .cyc(cyc), .stb(stb),
		.we(we), .adr(adr), .sel(sel), .wdata(wdata));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_issue_master.xfer(0, 1'b1, a, 4'hF, d, q);
	endtask
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		u_issue_master.xfer(1, 1'b0, a, 4'hF, 32'h0, q);
		chk(what, exp, q);
	endtask
	function automatic logic [31:0] ctl(input logic [2:0] op, input logic dg, input logic [3:0] d);
		return {12'h0, 4'h2, 4'h1, d, 3'h0, dg, 1'b1, op};
	endfunction
	task automatic end_sim();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_mismatch++;
			end_sim();
		end
	end

	initial begin
		rst = 1'b1;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			wr(8'h44, rows[i].a);
			wr(8'h48, rows[i].b);
			wr(CTRL_OFF, ctl(rows[i].op, 1'b1, 4'h3));
			wr(ISSUE_OFF, 32'h1);
			rdc("result", RESULT_OFF, rows[i].res);
			rdc("dest", 8'h4C, rows[i].res);
			rdc("flags", FLAGS_OFF, {28'h0, rows[i].flg});
			$display("row %0d done", i);
		end
		wr(8'h44, 32'h00010001);
		wr(8'h48, 32'h00020002);
		wr(CTRL_OFF, ctl(OP_LANE_ADD_HALFWORDS, 1'b0, 4'h3));
		wr(ISSUE_OFF, 32'h1);
		rdc("first source", 8'h44, 32'h00030003);
		rdc("dest kept", 8'h4C, rows[8].res);
		rdc("status done", STATUS_OFF, 32'h0000_0A01);
		$display("default destination done");
		wr(FLAGS_OFF, 32'h5);
		foreach (bad_ctrl[i]) begin
			wr(CTRL_OFF, bad_ctrl[i]);
			wr(ISSUE_OFF, 32'h1);
			rdc("refused dest", 8'h4C, rows[8].res);
			rdc("refused flags", FLAGS_OFF, 32'h5);
			u_issue_master.xfer(2, 1'b0, STATUS_OFF, 4'hF, 32'h0, q);
			chk("refusal cause", 32'h1, {31'h0, q[bad_bit[i]]});
		end
		rdc("status after refusals", STATUS_OFF, 32'h0000_0A08);
		$display("refusals done");
		wr(8'h20, 32'hFFFFFFFF);
		rdc("unmapped", 8'h20, 32'h0);
		@(posedge clk);
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdc("ctrl reset", CTRL_OFF, CTRL_RESET);
		rdc("flags reset", FLAGS_OFF, WORD_RESET);
		rdc("status reset", STATUS_OFF, WORD_RESET);
		rdc("result reset", RESULT_OFF, WORD_RESET);
		rdc("bank reset", 8'h4C, WORD_RESET);
		u_issue_master.xfer(3, 1'b1, 8'h4C, 4'h6, 32'h11223344, q);
		rdc("byte lanes", 8'h4C, 32'h00223300);
		$display("reset and lanes done");
		end_sim();
	end
endmodule

bind unsigned_simd_add_unit simd_add_chk u_simd_add_chk (.CLK(CLK), .RST(RST), .CYC_I(CYC_I),
	.STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
	.ACK_O(ACK_O));
`default_nettype wire
